// ===== rtl/fbio_regs.vh
/*
  Constants of the fieldbus station I/O image block: request kinds, control
  command bits, station address range and supported bit rates.
  Assumes inclusion by bare name from the rtl/ design files.
*/
`ifndef FBIO_REGS_VH
`define FBIO_REGS_VH

// ----------------------------------------------------------------------------
// Request kinds
// ----------------------------------------------------------------------------
`define FBIO_KIND_W        2
`define FBIO_KIND_CYCLIC   2'h0
`define FBIO_KIND_ACYCLIC  2'h1
`define FBIO_KIND_CONTROL  2'h2

// ----------------------------------------------------------------------------
// Control command bit positions
// ----------------------------------------------------------------------------
`define FBIO_CMD_W         4
`define FBIO_CMD_FREEZE    0
`define FBIO_CMD_UNFREEZE  1
`define FBIO_CMD_SYNC      2
`define FBIO_CMD_UNSYNC    3

// ----------------------------------------------------------------------------
// Station addresses
// ----------------------------------------------------------------------------
`define FBIO_ADDR_W        7
`define FBIO_ADDR_MIN      7'h01
`define FBIO_ADDR_MAX      7'h7D
`define FBIO_ADDR_GROUP    7'h7F

// ----------------------------------------------------------------------------
// Bit rates in bit/s, clock in Hz, rate selector codes
// ----------------------------------------------------------------------------
`define FBIO_CLK_HZ        25000000
`define FBIO_RATE_W        4
`define FBIO_RATE_CODE_MAX 4'h9
`define FBIO_BPS_0         9600
`define FBIO_BPS_1         19200
`define FBIO_BPS_2         45450
`define FBIO_BPS_3         93750
`define FBIO_BPS_4         187500
`define FBIO_BPS_5         500000
`define FBIO_BPS_6         1500000
`define FBIO_BPS_7         3000000
`define FBIO_BPS_8         6000000
`define FBIO_BPS_9         12000000
`define FBIO_DIV_W         12

`endif

// ===== rtl/fbio_fifo.v
/*
  Synchronous FIFO in flip-flops with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module fbio_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_sys_in,
  input  wire             sys_rst_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output wire [WIDTH-1:0] rd_data_out,
  output wire [AW:0]      level_out
);

  // --------------------------------------------------------------------------
  // Storage and pointers
  // --------------------------------------------------------------------------
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr;
  reg  [AW-1:0]    rd_ptr;
  reg  [AW:0]      count;
  wire             do_wr;
  wire             do_rd;

  assign wr_ready_out = (count != DEPTH[AW:0]);
  assign rd_valid_out = (count != {(AW+1){1'b0}});
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_valid_out & rd_ready_in;
  assign rd_data_out  = mem[rd_ptr];
  assign level_out    = count;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      ptr_inc = (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ? {AW{1'b0}}
                                                           : p + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  always @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (do_rd) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (do_wr && !do_rd) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (do_rd && !do_wr) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // fbio_fifo

`default_nettype wire

// ===== rtl/fbio_io_freeze_sync.v
/*
  Process image handling of a fieldbus slave station: cyclic exchange,
  acyclic transfers through a FIFO, input freezing and output holding,
  station address check and bit-rate tick generation.
  Assumes an upstream frame decoder that presents one decoded request at a
  time, synchronous to clk_sys_in, and a user that drains acyclic data.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fbio_regs.vh"

// Notes on behaviour
// - Each addressed cyclic request updates the output image and answers with the input image.
// - With the extended level enabled, acyclic requests are buffered and acknowledged.
// - FREEZE captures the inputs and later answers report that snapshot.
// - A further FREEZE while frozen re-captures the current inputs.
// - UNFREEZE ends freezing so that answers carry live inputs again.
// - SYNC holds the physical outputs at their present values.
// - While held, cyclic output data is stored but the outputs stay put.
// - A new SYNC while held drives the last stored data out and holds again.
// - UNSYNC ends holding and every later cyclic frame updates the outputs.
// - The station answers only requests taken from the master, never on its own.
// - Only a station address of 1 to 125 is accepted and used for matching.
// - The bit tick covers rates from 9.6 kbit/s up to 12 Mbit/s.
module fbio_io_freeze_sync #(
  parameter IO_W       = 8,
  parameter ACY_W      = 8,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW    = 5
) (
  input  wire                    clk_sys_in,
  input  wire                    sys_rst_in,
  input  wire [`FBIO_ADDR_W-1:0] station_addr_in,
  input  wire                    ext_level_in,
  input  wire [`FBIO_RATE_W-1:0] rate_sel_in,
  input  wire                    req_valid_in,
  output wire                    req_ready_out,
  input  wire [`FBIO_ADDR_W-1:0] req_dest_in,
  input  wire [`FBIO_KIND_W-1:0] req_kind_in,
  input  wire [`FBIO_CMD_W-1:0]  req_cmd_in,
  input  wire [IO_W-1:0]         req_out_data_in,
  input  wire [ACY_W-1:0]        req_acy_data_in,
  output reg                     rsp_valid_out,
  output reg  [`FBIO_KIND_W-1:0] rsp_kind_out,
  output reg  [IO_W-1:0]         rsp_in_data_out,
  input  wire [IO_W-1:0]         phys_in_in,
  output reg  [IO_W-1:0]         phys_out_out,
  output wire                    acy_valid_out,
  input  wire                    acy_ready_in,
  output wire [ACY_W-1:0]        acy_data_out,
  output reg                     addr_ok_out,
  output reg                     freeze_active_out,
  output reg                     sync_active_out,
  output reg                     rate_ok_out,
  output reg                     bit_tick_out
);

  // --------------------------------------------------------------------------
  // Internal signals
  // --------------------------------------------------------------------------
  reg  [`FBIO_ADDR_W-1:0] own_addr;
  reg  [IO_W-1:0]         in_snap;
  reg  [IO_W-1:0]         out_buf;
  reg  [`FBIO_DIV_W-1:0]  div_cnt;
  wire [`FBIO_DIV_W-1:0]  div_load;
  wire                    addr_match;
  wire                    group_hit;
  wire                    take;
  wire                    is_cyclic;
  wire                    is_acyclic;
  wire                    is_control;
  wire                    acy_wr_valid;
  wire                    acy_wr_ready;
  wire                    cmd_freeze;
  wire                    cmd_unfreeze;
  wire                    cmd_sync;
  wire                    cmd_unsync;

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function addr_in_range;
    input [`FBIO_ADDR_W-1:0] a;
    begin
      addr_in_range = (a >= `FBIO_ADDR_MIN) && (a <= `FBIO_ADDR_MAX);
    end
  endfunction

  function [`FBIO_DIV_W-1:0] rate_div;
    input [`FBIO_RATE_W-1:0] sel;
    reg   [31:0]             bps;
    reg   [31:0]             d;
    begin
      bps = `FBIO_BPS_0;
      case (sel)
        4'h0: bps = `FBIO_BPS_0;
        4'h1: bps = `FBIO_BPS_1;
        4'h2: bps = `FBIO_BPS_2;
        4'h3: bps = `FBIO_BPS_3;
        4'h4: bps = `FBIO_BPS_4;
        4'h5: bps = `FBIO_BPS_5;
        4'h6: bps = `FBIO_BPS_6;
        4'h7: bps = `FBIO_BPS_7;
        4'h8: bps = `FBIO_BPS_8;
        4'h9: bps = `FBIO_BPS_9;
        default: bps = `FBIO_BPS_0;
      endcase
      // Nearest whole divisor; at the top rate the clock only allows about 2
      d = (`FBIO_CLK_HZ + (bps / 2)) / bps;
      if (d < 32'd1) begin
        d = 32'd1;
      end
      rate_div = d[`FBIO_DIV_W-1:0];
    end
  endfunction

  // --------------------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------------------
  assign is_cyclic  = (req_kind_in == `FBIO_KIND_CYCLIC);
  assign is_acyclic = (req_kind_in == `FBIO_KIND_ACYCLIC);
  assign is_control = (req_kind_in == `FBIO_KIND_CONTROL);

  assign addr_match = addr_ok_out && (req_dest_in == own_addr);
  // Control commands reach a group, so the group address also hits
  assign group_hit  = addr_ok_out && is_control && (req_dest_in == `FBIO_ADDR_GROUP);

  // Acyclic data stalls the master side while the FIFO is full
  assign req_ready_out = !(is_acyclic && ext_level_in && addr_match) || acy_wr_ready;

  assign take = req_valid_in && req_ready_out && (addr_match || group_hit);

  assign cmd_freeze   = take && is_control && req_cmd_in[`FBIO_CMD_FREEZE];
  assign cmd_unfreeze = take && is_control && req_cmd_in[`FBIO_CMD_UNFREEZE];
  assign cmd_sync     = take && is_control && req_cmd_in[`FBIO_CMD_SYNC];
  assign cmd_unsync   = take && is_control && req_cmd_in[`FBIO_CMD_UNSYNC];

  // Acyclic data only with extended level
  assign acy_wr_valid = take && is_acyclic && ext_level_in;

  // --------------------------------------------------------------------------
  // Station address latch
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      own_addr    <= `FBIO_ADDR_MIN;
      addr_ok_out <= 1'b0;
    end else begin
      own_addr <= station_addr_in;
      // Address 0 and above 125 refused
      addr_ok_out <= addr_in_range(station_addr_in);
    end
  end

  // --------------------------------------------------------------------------
  // Input freezing
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      in_snap           <= {IO_W{1'b0}};
      freeze_active_out <= 1'b0;
    end else begin
      if (cmd_unfreeze) begin
        freeze_active_out <= 1'b0;
      end else if (cmd_freeze) begin
        in_snap           <= phys_in_in;
        freeze_active_out <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Output holding and output image
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_buf         <= {IO_W{1'b0}};
      phys_out_out    <= {IO_W{1'b0}};
      sync_active_out <= 1'b0;
    end else begin
      if (take && is_cyclic) begin
        out_buf <= req_out_data_in;
        if (!sync_active_out) begin
          phys_out_out <= req_out_data_in;
        end
      end
      if (cmd_unsync) begin
        sync_active_out <= 1'b0;
      end else if (cmd_sync) begin
        sync_active_out <= 1'b1;
        if (sync_active_out) begin
          phys_out_out <= out_buf;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Answer to the master
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rsp_valid_out   <= 1'b0;
      rsp_kind_out    <= `FBIO_KIND_CYCLIC;
      rsp_in_data_out <= {IO_W{1'b0}};
    end else begin
      // Answer only to an addressed request
      rsp_valid_out <= take && addr_match && (is_cyclic || (is_acyclic && ext_level_in));
      if (take && addr_match && is_cyclic) begin
        rsp_kind_out <= `FBIO_KIND_CYCLIC;
        rsp_in_data_out <= freeze_active_out ? in_snap : phys_in_in;
      end else if (take && addr_match && is_acyclic && ext_level_in) begin
        rsp_kind_out <= `FBIO_KIND_ACYCLIC;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bit-rate tick
  // --------------------------------------------------------------------------
  assign div_load = rate_div(rate_sel_in) - {{(`FBIO_DIV_W-1){1'b0}}, 1'b1};

  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_cnt      <= {`FBIO_DIV_W{1'b0}};
      bit_tick_out <= 1'b0;
      rate_ok_out  <= 1'b0;
    end else begin
      rate_ok_out <= (rate_sel_in <= `FBIO_RATE_CODE_MAX);
      if (div_cnt == {`FBIO_DIV_W{1'b0}}) begin
        div_cnt      <= div_load;
        bit_tick_out <= 1'b1;
      end else begin
        div_cnt      <= div_cnt - {{(`FBIO_DIV_W-1){1'b0}}, 1'b1};
        bit_tick_out <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Acyclic data buffer
  // --------------------------------------------------------------------------
  fbio_fifo #(
    .WIDTH (ACY_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_acy_fifo (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .wr_valid_in  (acy_wr_valid),
    .wr_ready_out (acy_wr_ready),
    .wr_data_in   (req_acy_data_in),
    .rd_valid_out (acy_valid_out),
    .rd_ready_in  (acy_ready_in),
    .rd_data_out  (acy_data_out),
    .level_out    ()
  );

endmodule // fbio_io_freeze_sync

`default_nettype wire

// ===== test/fbio_chk_properties.sv
/*
  Checker of the station I/O block, seeing its top-level ports only.
  Assumes one clock and the asynchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module fbio_chk (
  input wire logic       clk_sys_in,
  input wire logic       sys_rst_in,
  input wire logic [6:0] station_addr_in,
  input wire logic       ext_level_in,
  input wire logic       req_valid_in,
  input wire logic       req_ready_out,
  input wire logic [6:0] req_dest_in,
  input wire logic [1:0] req_kind_in,
  input wire logic [3:0] req_cmd_in,
  input wire logic [7:0] req_out_data_in,
  input wire logic       rsp_valid_out,
  input wire logic [1:0] rsp_kind_out,
  input wire logic [7:0] rsp_in_data_out,
  input wire logic [7:0] phys_in_in,
  input wire logic [7:0] phys_out_out,
  input wire logic       acy_valid_out,
  input wire logic       addr_ok_out,
  input wire logic       freeze_active_out,
  input wire logic       sync_active_out
);
  // Request taken by this station, by kind
  wire       grp = (req_dest_in == 7'h7F) && (req_kind_in == 2'h2);
  wire       tk  = req_valid_in && req_ready_out && addr_ok_out &&
                   ((req_dest_in == station_addr_in) || grp);
  wire       cyc = tk && (req_kind_in == 2'h0);
  wire       ctl = tk && (req_kind_in == 2'h2);
  wire [3:0] c   = req_cmd_in;
  // Model of the input snapshot kept by the station
  logic [7:0] snap_m;
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      snap_m <= 8'h00;
    end else if (ctl && c[0] && !c[1]) begin
      snap_m <= phys_in_in;
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  a_cyc_answer: assert property (
    cyc |=> rsp_valid_out && (rsp_kind_out == 2'h0))
    else $error("cyclic request not answered");
  a_acy_answer: assert property (
    tk && (req_kind_in == 2'h1) && ext_level_in
    |=> rsp_valid_out && (rsp_kind_out == 2'h1) && acy_valid_out)
    else $error("acyclic request not answered");
  a_freeze_snap: assert property (
    cyc && freeze_active_out |=> rsp_in_data_out == snap_m)
    else $error("answer is not the frozen snapshot");
  a_live_inputs: assert property (
    cyc && !freeze_active_out |=> rsp_in_data_out == $past(phys_in_in))
    else $error("answer is not the live inputs");
  a_hold_outputs: assert property (
    sync_active_out && cyc |=> $stable(phys_out_out))
    else $error("held outputs changed");
  a_out_update: assert property (
    !sync_active_out && cyc |=> phys_out_out == $past(req_out_data_in))
    else $error("outputs not updated");
  a_freeze_indep: assert property (
    ctl && (c[3:2] == 2'h0) |=> $stable(sync_active_out) && $stable(phys_out_out))
    else $error("freeze command touched the outputs");
  a_no_unsolicited: assert property (
    rsp_valid_out |-> $past(tk))
    else $error("answer without a request");
  c_refreeze: cover property (ctl && c[0] && !c[1] && freeze_active_out);
  c_resync: cover property (ctl && c[2] && !c[3] && sync_active_out);
  c_fifo_full: cover property (req_valid_in && !req_ready_out);
endmodule // fbio_chk
bind fbio_io_freeze_sync fbio_chk fbio_chk_inst (
  .clk_sys_in, .sys_rst_in, .station_addr_in, .ext_level_in, .req_valid_in, .req_ready_out,
  .req_dest_in, .req_kind_in, .req_cmd_in, .req_out_data_in, .rsp_valid_out, .rsp_kind_out,
  .rsp_in_data_out, .phys_in_in, .phys_out_out, .acy_valid_out, .addr_ok_out,
  .freeze_active_out, .sync_active_out);
`default_nettype wire

// ===== test/fbio_master.sv
/*
  Bus-master model: one request at a time, held until the station is ready or 100 cycles pass.
  Assumes its tasks are called at a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module fbio_master (
  input  wire logic       clk_sys_in,
  input  wire logic       req_ready_out,
  output var  logic       req_valid_in    = 1'b0,
  output var  logic [6:0] req_dest_in     = 7'h00,
  output var  logic [1:0] req_kind_in     = 2'h0,
  output var  logic [3:0] req_cmd_in      = 4'h0,
  output var  logic [7:0] req_out_data_in = 8'h00,
  output var  logic [7:0] req_acy_data_in = 8'h00
);
  task automatic send(input logic [6:0] d, input logic [1:0] k, input logic [3:0] c,
                      input logic [7:0] v);
    int n;
    n = 0;
    req_valid_in    <= 1'b1;
    req_dest_in     <= d;
    req_kind_in     <= k;
    req_cmd_in      <= c;
    req_out_data_in <= v;
    req_acy_data_in <= v;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (!req_ready_out && (n < 100));
  endtask
  // Released data and command lines carry no stale value; destination and kind keep theirs
  task automatic idle();
    req_valid_in    <= 1'b0;
    req_cmd_in      <= ~req_cmd_in;
    req_out_data_in <= ~req_out_data_in;
    req_acy_data_in <= ~req_acy_data_in;
  endtask
endmodule // fbio_master
`default_nettype wire

// ===== test/tb_top.sv
/*
  Self-checking bench of the station I/O block driven by a master model.
  Assumes the design files and their constants header under rtl/.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fbio_regs.vh"
module tb_top;
  logic       clk_sys_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic [6:0] station_addr_in = 7'h05;
  logic       ext_level_in = 1'b0;
  logic [3:0] rate_sel_in = 4'h9;
  logic [7:0] phys_in_in = 8'h00;
  logic       acy_ready_in = 1'b0;
  wire  [6:0] req_dest_in;
  wire  [3:0] req_cmd_in;
  wire  [1:0] req_kind_in, rsp_kind_out;
  wire  [7:0] req_out_data_in, req_acy_data_in, rsp_in_data_out, phys_out_out, acy_data_out;
  wire        req_valid_in, req_ready_out, rsp_valid_out, acy_valid_out, addr_ok_out;
  wire        freeze_active_out, sync_active_out, rate_ok_out, bit_tick_out;
  int         n_errors = 0;
  int         checks_done = 0;
  logic       frz = 1'b0;
  logic       syn = 1'b0;
  logic [7:0] snap = 8'h00;
  logic [7:0] stored = 8'h00;
  logic [7:0] outv = 8'h00;
  logic [7:0] q [$];
  int         adr [4] = '{0, 126, 125, 1};
  int         cor [23] = '{1, 1, 4, 4, 5, 5, 10, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};
  int         bps [10] = '{`FBIO_BPS_0, `FBIO_BPS_1, `FBIO_BPS_2, `FBIO_BPS_3, `FBIO_BPS_4,
                           `FBIO_BPS_5, `FBIO_BPS_6, `FBIO_BPS_7, `FBIO_BPS_8, `FBIO_BPS_9};
  fbio_io_freeze_sync fbio_io_freeze_sync_inst (
    .clk_sys_in, .sys_rst_in, .station_addr_in, .ext_level_in, .rate_sel_in, .req_valid_in,
    .req_ready_out, .req_dest_in, .req_kind_in, .req_cmd_in, .req_out_data_in,
    .req_acy_data_in, .rsp_valid_out, .rsp_kind_out, .rsp_in_data_out, .phys_in_in,
    .phys_out_out, .acy_valid_out, .acy_ready_in, .acy_data_out, .addr_ok_out,
    .freeze_active_out, .sync_active_out, .rate_ok_out, .bit_tick_out);
  fbio_master fbio_master_inst (.clk_sys_in, .req_ready_out, .req_valid_in, .req_dest_in,
    .req_kind_in, .req_cmd_in, .req_out_data_in, .req_acy_data_in);
  always #20 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (exp !== got) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if ((n_errors == 0) && (checks_done > 0))
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic int exp_div(input int r);
    int b;
    b = bps[(r > 9) ? 0 : r];
    return (`FBIO_CLK_HZ + b / 2) / b;
  endfunction
  task automatic cyc(input logic [7:0] d);
    logic [7:0] p;
    p = 8'($urandom);
    phys_in_in <= p;
    fbio_master_inst.send(station_addr_in, 2'h0, 4'h0, d);
    fbio_master_inst.idle();
    stored = d;
    outv = syn ? outv : d;
    @(negedge clk_sys_in);
    chk("rsp_valid", 1, rsp_valid_out);
    chk("rsp_in_data", frz ? snap : p, rsp_in_data_out);
    chk("phys_out", outv, phys_out_out);
    @(posedge clk_sys_in);
  endtask
  task automatic ctl(input logic [3:0] c);
    logic [7:0] p;
    p = 8'($urandom);
    phys_in_in <= p;
    fbio_master_inst.send(7'h7F, 2'h2, c, 8'h00);
    fbio_master_inst.idle();
    snap = (c[0] && !c[1]) ? p : snap;
    frz = (frz | c[0]) & ~c[1];
    // Unsync in the same command wins, so the outputs stay as they were
    outv = (c[2] && !c[3] && syn) ? stored : outv;
    syn = (syn | c[2]) & ~c[3];
    @(negedge clk_sys_in);
    chk("freeze", frz, freeze_active_out);
    chk("sync", syn, sync_active_out);
    chk("phys_out", outv, phys_out_out);
    chk("rsp_valid", 0, rsp_valid_out);
    @(posedge clk_sys_in);
  endtask
  task automatic nores(input logic [6:0] d, input logic [1:0] k);
    fbio_master_inst.send(d, k, 4'h0, 8'h5A);
    fbio_master_inst.idle();
    @(negedge clk_sys_in);
    chk("no_answer", 0, rsp_valid_out);
    chk("phys_out", outv, phys_out_out);
    @(posedge clk_sys_in);
  endtask
  task automatic tick(output int n);
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while ((bit_tick_out !== 1'b1) && (n < 3000));
  endtask
  initial begin
    int i;
    int n;
    logic [7:0] w;
    i = $urandom(57);
    repeat (16) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    foreach (cor[k]) begin
      ctl(4'(cor[k]));
      cyc(8'($urandom));
    end
    repeat (80) begin
      if ($urandom % 2)
        cyc(8'($urandom));
      else
        ctl(4'($urandom));
    end
    $display("test freeze_sync done");
    nores(station_addr_in + 7'h01, 2'h0);
    nores(station_addr_in, 2'h3);
    nores(station_addr_in, 2'h1);
    chk("acy_valid", 0, acy_valid_out);
    foreach (adr[k]) begin
      station_addr_in <= 7'(adr[k]);
      repeat (3) @(posedge clk_sys_in);
      chk("addr_ok", (adr[k] >= 1) && (adr[k] <= 125), addr_ok_out);
      if ((adr[k] >= 1) && (adr[k] <= 125))
        cyc(8'($urandom));
      else
        nores(7'(adr[k]), 2'h0);
    end
    $display("test addressing done");
    ext_level_in <= 1'b1;
    for (i = 0; i < 32; i++) begin
      w = 8'($urandom);
      q.push_back(w);
      fbio_master_inst.send(station_addr_in, 2'h1, 4'h0, w);
    end
    fbio_master_inst.send(station_addr_in, 2'h1, 4'h0, 8'h00);
    chk("ready_full", 0, req_ready_out);
    fbio_master_inst.idle();
    for (i = 0; (q.size() > 0) && (i < 1000); i++) begin
      @(posedge clk_sys_in);
      if (acy_valid_out && acy_ready_in)
        chk("acy_data", q.pop_front(), acy_data_out);
      acy_ready_in <= 1'($urandom);
    end
    @(negedge clk_sys_in);
    chk("acy_left", 0, 12'(q.size()));
    chk("acy_empty", 0, acy_valid_out);
    @(posedge clk_sys_in);
    acy_ready_in <= 1'b0;
    $display("test acyclic done");
    for (i = 0; i <= 10; i++) begin
      rate_sel_in <= 4'(i);
      tick(n);
      tick(n);
      tick(n);
      chk("tick_gap", 12'(exp_div(i)), 12'(n));
      chk("rate_ok", i < 10, rate_ok_out);
    end
    $display("test bit_rate done");
    conclude();
  end
  // Cut a hang short
  initial begin
    #(40 * 60000);
    n_errors++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
